// >>> verilog/wr_engine_pkg.sv
// Constants and types shared by the processor bus write engine
package wr_engine_pkg;
  // Port width codes of the addressed sub-region
  typedef enum logic [1:0] {
    PORT_W32 = 2'b00,
    PORT_W16 = 2'b01,
    PORT_W8 = 2'b10
  } port_width_type;

  // Engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_HOLD = 3'b010,
    ST_DATA = 3'b011,
    ST_DONE = 3'b100
  } wr_state_type;

  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam logic [3:0] BE_NONE = 4'h0;
  localparam logic [1:0] NLANE_IDLE_N = 2'h3;
  localparam logic [2:0] CNT_ZERO = 3'h0;
  localparam logic [2:0] CNT_ONE = 3'h1;
  localparam logic [3:0] LOW_ADDR_ZERO = 4'h0;
endpackage

// >>> verilog/cpu_bus_write_engine.sv
// Write engine of a multiplexed address/data processor bus
`timescale 1ns/10ps
`default_nettype none
module cpu_bus_write_engine (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Request from the write buffer
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic [wr_engine_pkg::ADDR_W-1:0] req_addr_i,
  input wire logic [wr_engine_pkg::DATA_W-1:0] req_data_i,
  input wire logic [3:0] req_be_i,
  input wire wr_engine_pkg::port_width_type req_port_width_i,
  input wire logic late_address_release_mode_i,
  // Bus answers from the pins
  input wire logic ack_n_i,
  input wire logic transfer_fault_n_i,
  // Bus pins
  output logic [wr_engine_pkg::DATA_W-1:0] ad_o,
  output logic ad_oe_o,
  output logic [3:0] low_addr_o,
  output logic ale_o,
  output logic wr_n_o,
  output logic last_n_o,
  output logic [3:0] be_n_o,
  output logic [1:0] narrow_lane_select_n_o,
  // Completion report
  output logic done_o,
  output logic fault_o
);
  import wr_engine_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [2:0] ack_sync_q;
  logic [2:0] flt_sync_q;
  logic ack_q;
  logic flt_q;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ack_sync_q <= 3'h7;
      flt_sync_q <= 3'h7;
    end else begin
      ack_sync_q <= {ack_sync_q[1:0], ack_n_i};
      flt_sync_q <= {flt_sync_q[1:0], transfer_fault_n_i};
    end
  end

  // Level counts once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ack_q <= 1'b0;
      flt_q <= 1'b0;
    end else begin
      if (ack_sync_q[1] == ack_sync_q[2]) begin
        ack_q <= ~ack_sync_q[2];
      end
      if (flt_sync_q[1] == flt_sync_q[2]) begin
        flt_q <= ~flt_sync_q[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Number of data for a store given port width and byte enables
  function automatic logic [2:0] datum_count(input port_width_type pw, input logic [3:0] be);
    logic [2:0] n;
    n = CNT_ONE;
    if (pw == PORT_W8) begin
      n = 3'(be[0]) + 3'(be[1]) + 3'(be[2]) + 3'(be[3]);
    end else if (pw == PORT_W16) begin
      n = ((be[1:0] != 2'h0) && (be[3:2] != 2'h0)) ? 3'h2 : CNT_ONE;
    end
    if (n == CNT_ZERO) begin
      n = CNT_ONE;
    end
    return n;
  endfunction

  // First enabled byte index
  function automatic logic [1:0] first_byte(input logic [3:0] be);
    logic [1:0] i;
    i = 2'h0;
    if (be[0]) i = 2'h0;
    else if (be[1]) i = 2'h1;
    else if (be[2]) i = 2'h2;
    else if (be[3]) i = 2'h3;
    return i;
  endfunction

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  wr_state_type state_q;
  port_width_type pw_q;
  logic [DATA_W-1:0] data_q;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;
  logic [3:0] be_q;
  logic [2:0] left_q;
  logic hold_q;
  logic term_ack;
  logic term_flt;
  logic sampling;

  assign sampling = (state_q == ST_HOLD) || (state_q == ST_DATA);
  assign term_flt = sampling && flt_q;
  assign term_ack = sampling && ack_q && !flt_q;
  assign req_ready_o = (state_q == ST_IDLE);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (req_valid_i) begin
            state_q <= ST_ADDR;
          end
        end
        ST_ADDR: begin
          // Late release adds a hold phase
          state_q <= hold_q ? ST_HOLD : ST_DATA;
        end
        ST_HOLD, ST_DATA: begin
          if (term_flt) begin
            state_q <= ST_DONE;
          // Each datum waits for its own
          end else if (term_ack && (left_q == CNT_ONE)) begin
            state_q <= ST_DONE;
          end else begin
            state_q <= ST_DATA;
          end
        end
        ST_DONE: begin
          // Synchronised answers lag the pins; a stale acknowledge would
          // otherwise end the next write before it is answered
          if (!ack_q && !flt_q) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Request capture and datum stepping
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pw_q <= PORT_W32;
      data_q <= '0;
      be_q <= BE_NONE;
      left_q <= CNT_ZERO;
      hold_q <= 1'b0;
    end else if (state_q == ST_IDLE && req_valid_i) begin
      pw_q <= req_port_width_i;
      data_q <= req_data_i;
      be_q <= req_be_i;
      hold_q <= late_address_release_mode_i;
      left_q <= datum_count(req_port_width_i, req_be_i);
    end else if (term_ack && (left_q != CNT_ONE)) begin
      left_q <= left_q - CNT_ONE;
    end
  end

  // Address of the current datum; stepped at the acknowledge so that the
  // low address and lane pins move on the same edge as the final-datum flag
  always_comb begin
    addr_d = addr_q;
    if (state_q == ST_IDLE && req_valid_i) begin
      if (req_port_width_i == PORT_W8) begin
        addr_d = {req_addr_i[ADDR_W-1:2], first_byte(req_be_i)};
      end else if (req_port_width_i == PORT_W16) begin
        addr_d = {req_addr_i[ADDR_W-1:2], (req_be_i[1:0] == 2'h0), 1'b0};
      end else begin
        addr_d = {req_addr_i[ADDR_W-1:2], 2'h0};
      end
    end else if (term_ack && (left_q != CNT_ONE)) begin
      if (pw_q == PORT_W8) begin
        addr_d[3:0] = addr_q[3:0] + 4'h1;
      end else begin
        addr_d[3:1] = addr_q[3:1] + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      addr_q <= '0;
    end else begin
      addr_q <= addr_d;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  logic [1:0] lanes;
  logic [3:0] be_d;
  port_width_type pw_d;
  always_comb begin
    pw_d = pw_q;
    be_d = be_q;
    if (state_q == ST_IDLE && req_valid_i) begin
      pw_d = req_port_width_i;
      be_d = req_be_i;
    end
    lanes = addr_d[1] ? be_d[3:2] : be_d[1:0];
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ad_o <= '0;
      ad_oe_o <= 1'b0;
      ale_o <= 1'b0;
      wr_n_o <= 1'b1;
      last_n_o <= 1'b1;
      be_n_o <= 4'hf;
      narrow_lane_select_n_o <= NLANE_IDLE_N;
      low_addr_o <= LOW_ADDR_ZERO;
    end else begin
      ad_oe_o <= (state_q != ST_IDLE) || req_valid_i;
      ale_o <= (state_q == ST_IDLE) && req_valid_i;
      if (state_q == ST_IDLE && req_valid_i) begin
        ad_o <= req_addr_i;
        wr_n_o <= 1'b0;
        be_n_o <= ~req_be_i;
        last_n_o <= (datum_count(req_port_width_i, req_be_i) == CNT_ONE) ? 1'b0 : 1'b1;
      end else if (state_q == ST_ADDR && !hold_q) begin
        ad_o <= data_q;
      end else if (state_q == ST_HOLD) begin
        ad_o <= data_q;
      end
      if (term_flt || (term_ack && left_q == CNT_ONE)) begin
        wr_n_o <= 1'b1;
        last_n_o <= 1'b1;
        be_n_o <= 4'hf;
      end else if (term_ack && left_q == 3'h2) begin
        last_n_o <= 1'b0;
      end
      if (pw_d == PORT_W16 && (state_q != ST_IDLE || req_valid_i)) begin
        narrow_lane_select_n_o <= ~lanes;
      end else begin
        narrow_lane_select_n_o <= NLANE_IDLE_N;
      end
      low_addr_o <= addr_d[3:0];
    end
  end

  // ----------------------------------------------------------------
  // Completion report
  // ----------------------------------------------------------------
  // Fault only reported, no exception
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      done_o <= 1'b0;
      fault_o <= 1'b0;
    end else begin
      done_o <= term_flt || (term_ack && left_q == CNT_ONE);
      fault_o <= term_flt;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/wr_engine_props.sv
// Port-level timing checks for the bus write engine
`timescale 1ns/10ps
`default_nettype none
module wr_engine_props (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Watched ports
  input wire logic req_valid_i,
  input wire logic req_ready_o,
  input wire logic ale_o,
  input wire logic wr_n_o,
  input wire logic ad_oe_o,
  input wire logic done_o,
  input wire logic fault_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_take;
    req_valid_i && req_ready_o;
  endsequence
  sequence s_end;
    $rose(wr_n_o);
  endsequence
  a_strobe_on_take: assert property (s_take |=> !wr_n_o && ale_o)
    else $error("no strobe after request");
  a_ale_single: assert property (ale_o |=> !ale_o)
    else $error("address strobe too long");
  a_done_at_end: assert property (s_end |-> done_o)
    else $error("strobe released without done");
  a_done_pulse: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  a_fault_in_done: assert property (fault_o |-> done_o)
    else $error("fault reported outside done");
  // Ready waits for the synchronised answers to drop after the end
  a_ready_after: assert property (done_o |-> ##[1:6] req_ready_o)
    else $error("engine not ready after end");
  a_drive_in_write: assert property (!wr_n_o |-> ad_oe_o && !req_ready_o)
    else $error("bus not driven during write");
  a_done_needs_write: assert property (done_o |-> $past(!wr_n_o))
    else $error("done without a write");
endmodule
bind cpu_bus_write_engine wr_engine_props wr_engine_props_i (
  .clk_i(clk_i),
  .sys_rst_i(sys_rst_i),
  .req_valid_i(req_valid_i),
  .req_ready_o(req_ready_o),
  .ale_o(ale_o),
  .wr_n_o(wr_n_o),
  .ad_oe_o(ad_oe_o),
  .done_o(done_o),
  .fault_o(fault_o)
);
`default_nettype wire

// >>> testbench/bus_answer_model.sv
// Memory controller answering writes with acknowledge or fault
`timescale 1ns/10ps
`default_nettype none
module bus_answer_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Controls
  input wire logic [3:0] waits_i,
  input wire logic fault_i,
  // Bus
  input wire logic wr_n_i,
  output logic ack_n_o,
  output logic transfer_fault_n_o,
  output logic fault_latch_o
);
  logic [3:0] wait_q;
  logic hit;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || wr_n_i) begin
      wait_q <= 4'h0;
    end else if (wait_q != 4'hf) begin
      wait_q <= wait_q + 4'h1;
    end
  end
  assign hit = !wr_n_i && (wait_q >= waits_i);
  // held until strobe rises; idle lines sit at pull-up
  assign ack_n_o = !hit;
  assign transfer_fault_n_o = !(hit && fault_i);
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      fault_latch_o <= 1'b0;
    end else if (!transfer_fault_n_o) begin
      fault_latch_o <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/test_cpu_bus_write_engine.sv
// Self-checking bench for the bus write engine
`timescale 1ns/10ps
`default_nettype none
module test_cpu_bus_write_engine;
  import wr_engine_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic req_valid = 1'b0;
  logic [ADDR_W-1:0] req_addr = 32'h0000_1000;
  logic [DATA_W-1:0] req_data = 32'ha5c3_1e70;
  logic [3:0] req_be = 4'h0;
  port_width_type req_pw = PORT_W32;
  logic late_mode = 1'b0;
  logic [3:0] waits = 4'h0;
  logic flt = 1'b0;
  logic ack_n, fault_n, req_ready, ale, wr_n, last_n, done, fault, ad_oe, flt_latch;
  logic [DATA_W-1:0] ad;
  logic [3:0] low_addr, be_n;
  logic [1:0] lanes, lanes_seen;
  logic saw_last, got_fault, first_last;
  logic [DATA_W-1:0] ad_early;
  logic [3:0] be_seen;
  int wcyc = 0;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  int n0, n, n16, n8;
  always #5 clk_i = ~clk_i;
  cpu_bus_write_engine cpu_bus_write_engine_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .req_valid_i(req_valid), .req_ready_o(req_ready), .req_addr_i(req_addr),
    .req_data_i(req_data), .req_be_i(req_be), .req_port_width_i(req_pw),
    .late_address_release_mode_i(late_mode), .ack_n_i(ack_n), .transfer_fault_n_i(fault_n),
    .ad_o(ad), .ad_oe_o(ad_oe), .low_addr_o(low_addr), .ale_o(ale), .wr_n_o(wr_n),
    .last_n_o(last_n), .be_n_o(be_n), .narrow_lane_select_n_o(lanes), .done_o(done),
    .fault_o(fault));
  bus_answer_model bus_answer_model_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .waits_i(waits), .fault_i(flt), .wr_n_i(wr_n), .ack_n_o(ack_n),
    .transfer_fault_n_o(fault_n), .fault_latch_o(flt_latch));
  task automatic end_of_test();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Ceiling well above the fewer than two hundred cycles the scenarios need
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (!wr_n) begin
      wcyc <= wcyc + 1;
      if (wcyc == 0) first_last <= last_n;
      if (wcyc == 1) ad_early <= ad;
      lanes_seen <= lanes;
      be_seen <= be_n;
      if (last_n === 1'b0) saw_last <= 1'b1;
    end else begin
      wcyc <= 0;
    end
    if (cycles == 3000) begin
      num_errors++;
      end_of_test();
    end
  end
  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t flag got %b want %b", $time, got, exp);
    end
  endtask
  task automatic chk_int(input int got, input int exp);
    check_count++;
    if (got != exp) begin
      num_errors++;
      $display("[ERR] %0t count got %0d want %0d", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t word got %h want %h", $time, got, exp);
    end
  endtask
  // One write; returns cycles from acceptance to done
  task automatic wr(input logic [3:0] be, input port_width_type pw, input logic [3:0] w,
      input logic f, output int cyc);
    saw_last = 1'b0;
    @(posedge clk_i);
    req_valid <= 1'b1;
    req_be <= be;
    req_pw <= pw;
    late_mode <= (pw == PORT_W8);
    waits <= w;
    flt <= f;
    do @(negedge clk_i); while (req_ready !== 1'b1);
    @(posedge clk_i);
    req_valid <= 1'b0;
    cyc = 0;
    do begin
      @(negedge clk_i);
      cyc++;
    end while (done !== 1'b1);
    got_fault = fault;
  endtask
  task automatic t_waits();
    wr(4'hf, PORT_W32, 4'h0, 1'b0, n0);
    chk_bit(got_fault, 1'b0);
    chk_bit(first_last, 1'b0);
    chk_bit(be_seen == 4'h0, 1'b1);
    chk_word(ad_early, req_data);
    chk_word(ad, req_data);
    chk_word({28'h0, low_addr}, 32'h0);
    wr(4'hf, PORT_W32, 4'h2, 1'b0, n);
    chk_int(n, n0 + 2);
  endtask
  task automatic t_fault();
    wr(4'hf, PORT_W32, 4'h1, 1'b1, n);
    chk_bit(got_fault, 1'b1);
    chk_int(n, n0 + 1);
    chk_bit(flt_latch, 1'b1);
    repeat (8) @(negedge clk_i);
    chk_bit(wr_n, 1'b1);
    chk_bit(req_ready, 1'b1);
  endtask
  task automatic t_narrow();
    wr(4'h2, PORT_W16, 4'h0, 1'b0, n);
    chk_int(n, n0);
    chk_bit(lanes_seen == 2'h1 && first_last == 1'b0, 1'b1);
    wr(4'he, PORT_W16, 4'h0, 1'b0, n16);
    chk_int(n16, n0 + 1);
    chk_bit(saw_last && first_last && lanes_seen == 2'h0, 1'b1);
    chk_word({28'h0, low_addr}, 32'h2);
    wr(4'hf, PORT_W8, 4'h0, 1'b0, n8);
    chk_int(n8, n0 + 3);
    chk_bit(saw_last && first_last, 1'b1);
    chk_word({28'h0, low_addr}, 32'h3);
    chk_word(ad_early, req_addr);
    wr(4'h3, PORT_W8, 4'h1, 1'b0, n);
    chk_int(n, n0 + 2);
    chk_word({28'h0, low_addr}, 32'h1);
    wr(4'hf, PORT_W8, 4'h0, 1'b1, n);
    chk_bit(got_fault, 1'b1);
    chk_int(n, n0);
    chk_word({28'h0, low_addr}, 32'h0);
  endtask
  task automatic t_reset();
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk_bit(wr_n & last_n & ~ale & ~ad_oe & ~done, 1'b1);
    chk_bit(be_n == 4'hf && lanes == 2'h3, 1'b1);
    chk_word(ad, 32'h0);
    @(posedge clk_i);
    sys_rst_i <= 1'b0;
    wr(4'hf, PORT_W32, 4'h0, 1'b0, n);
    chk_int(n, n0);
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_waits();
    t_fault();
    t_narrow();
    t_reset();
    end_of_test();
  end
endmodule
`default_nettype wire
